// ---- design/low_power_mode_controller.v ----
`include "lpm_consts.vh"
module low_power_mode_controller #(
    parameter WU_SCALE_SHIFT = 0
) (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rst_n,
    // Avalon-MM slave.
    input wire [4:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // Wake-up pins.
    input wire i_halt_release_pin,
    input wire [3:0] i_key_wakeup_inputs,
    // Interrupt sources.
    input wire [7:0] i_irq_request_latch,
    input wire i_wdt_irq,
    // Clock and core control.
    output reg o_hf_osc_en,
    output reg o_lf_osc_en,
    output reg o_slow_clk_sel,
    output reg o_cpu_stop,
    output reg o_wdt_stop,
    output reg o_periph_stop,
    output reg o_port_out_keep,
    output reg o_prescaler_clr,
    output reg o_resume_next,
    output reg o_irq_service
);
    localparam ST_RUN = 4'b0001;
    localparam ST_HALT = 4'b0010;
    localparam ST_WARM = 4'b0100;
    localparam ST_DOZE = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [7:0] sysctl1_r;
    reg [7:0] sysctl2_r;
    reg [3:0] keyen_r;
    reg master_ie_r;
    reg [7:0] irqen_r;
    reg release_method_select_eff_r;
    reg pin_m_r;
    reg pin_s_r;
    reg pin_d_r;
    reg [3:0] key_m_r;
    reg [3:0] key_s_r;
    reg ack_r;
    reg [31:0] rdata_r;
    reg wu_start_r;
    reg [`WU_W-1:0] wu_len_r;
    reg wu_slow_r;
    wire wu_busy;
    wire wu_done;
    wire acc;
    wire wr_en;
    wire wr_sc1;
    wire wr_sc2;
    wire pin_rise;
    wire lvl_release;
    wire halt_req;
    wire doze_req;
    wire doze_wake;
    wire dual_clk;

    // Lengths in fast or slow clock cycles; codes *01 and *11 ignore bit 2.
    function [`WU_W-1:0] wu_len;
        input [2:0] sel;
        input slow;
        reg [`WU_W-1:0] v;
        begin
            v = {`WU_W{1'b0}};
            casez ({slow, sel})
                4'b0000: v = 18'h3_0000;
                4'b0010: v = 18'h1_0000;
                4'b0100: v = 18'h0_C000;
                4'b0110: v = 18'h0_4000;
                4'b0?01: v = 18'h0_0C00;
                4'b0?11: v = 18'h0_0400;
                4'b1000: v = 18'h0_6000;
                4'b1010: v = 18'h0_2000;
                4'b1100: v = 18'h0_00C0;
                4'b1110: v = 18'h0_0040;
                4'b1?01: v = 18'h0_00C0;
                default: v = 18'h0_0040;
            endcase
            wu_len = v >> WU_SCALE_SHIFT;
            if (wu_len == {`WU_W{1'b0}}) begin
                wu_len = {{(`WU_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // Pins are synchronised on the always-running controller clock, which stays
    // alive while the core oscillators are off.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_m_r <= 1'b0;
            pin_s_r <= 1'b0;
            pin_d_r <= 1'b0;
            key_m_r <= 4'hF;
            key_s_r <= 4'hF;
        end else begin
            pin_m_r <= i_halt_release_pin;
            pin_s_r <= pin_m_r;
            pin_d_r <= pin_s_r;
            key_m_r <= i_key_wakeup_inputs;
            key_s_r <= key_m_r;
        end
    end

    assign pin_rise = pin_s_r & ~pin_d_r;
    assign lvl_release = pin_s_r | (|(keyen_r & ~key_s_r));
    assign dual_clk = sysctl2_r[`BIT_XTEN];

    // One wait state on every access; the access completes when ack_r is high.
    assign acc = (i_avs_read | i_avs_write) & ~ack_r;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign o_avs_readdata = rdata_r;
    assign wr_en = i_avs_write & ack_r & i_avs_byteenable[0];
    assign wr_sc1 = wr_en & (i_avs_address == {1'b0, `OFS_SYSCTL1});
    assign wr_sc2 = wr_en & (i_avs_address == {1'b0, `OFS_SYSCTL2});
    assign halt_req = wr_sc1 & i_avs_writedata[`BIT_STOP];
    assign doze_req = wr_sc2 & i_avs_writedata[`BIT_DOZE];
    assign doze_wake = |(i_irq_request_latch & irqen_r);

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc & i_avs_read) begin
                case (i_avs_address)
                    {1'b0, `OFS_SYSCTL1}: rdata_r <= {24'h00_0000, sysctl1_r[7:1], 1'b0};
                    {1'b0, `OFS_SYSCTL2}: rdata_r <= {24'h00_0000, sysctl2_r[7:4], 4'h0};
                    {1'b0, `OFS_KEYEN}: rdata_r <= {28'h000_0000, keyen_r};
                    {1'b0, `OFS_IRQCTL}: rdata_r <= {31'h0000_0000, master_ie_r};
                    `OFS_IRQEN: rdata_r <= {24'h00_0000, irqen_r};
                    `OFS_STATUS: rdata_r <= {22'h00_0000, key_s_r, pin_s_r, release_method_select_eff_r, state_r};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Next state of the mode sequencer.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (halt_req) begin
                    if (release_method_select_eff_r & lvl_release) begin
                        state_nxt = ST_WARM;
                    end else begin
                        state_nxt = ST_HALT;
                    end
                end else if (doze_req & ~i_wdt_irq) begin
                    state_nxt = ST_DOZE;
                end
            end
            ST_HALT: begin
                if (release_method_select_eff_r ? lvl_release : pin_rise) begin
                    state_nxt = ST_WARM;
                end
            end
            ST_WARM: begin
                // Withdrawn release conditions do not matter here.
                if (wu_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DOZE: begin
                if (doze_wake) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            // Reset ends any halt or doze and starts single-clock fast mode.
            state_r <= ST_RUN;
            sysctl1_r <= `RST_SYSCTL1;
            sysctl2_r <= `RST_SYSCTL2;
            keyen_r <= 4'h0;
            master_ie_r <= 1'b0;
            irqen_r <= 8'h00;
            release_method_select_eff_r <= 1'b0;
            wu_start_r <= 1'b0;
            wu_len_r <= {`WU_W{1'b0}};
            wu_slow_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wu_start_r <= 1'b0;
            if (wr_sc1) begin
                sysctl1_r <= i_avs_writedata[7:0];
                if (!i_avs_writedata[`BIT_RELEASE_METHOD_SELECT]) begin
                    release_method_select_eff_r <= 1'b0;
                end
            end else if (sysctl1_r[`BIT_RELEASE_METHOD_SELECT] & ~release_method_select_eff_r & pin_rise) begin
                release_method_select_eff_r <= 1'b1;
            end
            if (wr_sc2) begin
                sysctl2_r <= i_avs_writedata[7:0];
                if (i_avs_writedata[`BIT_DOZE] & i_wdt_irq) begin
                    sysctl2_r[`BIT_DOZE] <= 1'b0;
                end
            end
            if (wr_en & (i_avs_address == {1'b0, `OFS_KEYEN})) begin
                keyen_r <= i_avs_writedata[3:0];
            end
            if (wr_en & (i_avs_address == {1'b0, `OFS_IRQCTL})) begin
                master_ie_r <= i_avs_writedata[0];
            end
            if (wr_en & (i_avs_address == `OFS_IRQEN)) begin
                irqen_r <= i_avs_writedata[7:0];
            end
            if ((state_r != ST_WARM) & (state_nxt == ST_WARM)) begin
                wu_start_r <= 1'b1;
                // Return to slow mode only when dual-clock and resume bit set.
                wu_slow_r <= dual_clk & sysctl1_r[`BIT_RESUME_MODE_SELECT];
                wu_len_r <= wu_len(sysctl1_r[2:0], dual_clk & sysctl1_r[`BIT_RESUME_MODE_SELECT]);
                if (dual_clk & ~sysctl1_r[`BIT_RESUME_MODE_SELECT]) begin
                    sysctl2_r[`BIT_XEN] <= 1'b1;
                    sysctl2_r[`BIT_SYSCK] <= 1'b0;
                end else if (dual_clk) begin
                    sysctl2_r[`BIT_XEN] <= 1'b0;
                    sysctl2_r[`BIT_SYSCK] <= 1'b1;
                end else begin
                    sysctl2_r[`BIT_XEN] <= 1'b1;
                    sysctl2_r[`BIT_SYSCK] <= 1'b0;
                end
            end
            if ((state_r == ST_WARM) & wu_done) begin
                sysctl1_r[`BIT_STOP] <= 1'b0;
            end
            if ((state_r == ST_DOZE) & doze_wake) begin
                // The clock select is left alone, so the prior mode resumes.
                sysctl2_r[`BIT_DOZE] <= 1'b0;
            end
        end
    end

    warmup_timer u_warmup_timer (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(wu_start_r),
        .i_slow(wu_slow_r),
        .i_len(wu_len_r),
        .o_busy(wu_busy),
        .o_done(wu_done)
    );

    // Outputs are registered so the core sees clean levels and single pulses.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_hf_osc_en <= 1'b1;
            o_lf_osc_en <= 1'b0;
            o_slow_clk_sel <= 1'b0;
            o_cpu_stop <= 1'b0;
            o_wdt_stop <= 1'b0;
            o_periph_stop <= 1'b0;
            o_port_out_keep <= 1'b1;
            o_prescaler_clr <= 1'b0;
            o_resume_next <= 1'b0;
            o_irq_service <= 1'b0;
        end else begin
            // Oscillators are off in halt and restarted at warm-up.
            // On warm-up entry the enable follows the new target, not the stale register bit.
            o_hf_osc_en <= (state_nxt != ST_HALT) &
                           (((state_r != ST_WARM) & (state_nxt == ST_WARM)) ?
                            ~(dual_clk & sysctl1_r[`BIT_RESUME_MODE_SELECT]) : sysctl2_r[`BIT_XEN]);
            o_lf_osc_en <= (state_nxt != ST_HALT) & sysctl2_r[`BIT_XTEN];
            o_slow_clk_sel <= sysctl2_r[`BIT_SYSCK];
            // CPU and watchdog hold their state, PC included, while stopped.
            o_cpu_stop <= (state_nxt != ST_RUN);
            o_wdt_stop <= (state_nxt != ST_RUN);
            // Peripherals only stop for halt and warm-up.
            o_periph_stop <= (state_nxt == ST_HALT) | (state_nxt == ST_WARM) | wu_busy;
            o_port_out_keep <= (state_nxt != ST_HALT) | sysctl1_r[`BIT_OUTEN];
            o_prescaler_clr <= (state_r != ST_WARM) & (state_nxt == ST_WARM);
            // Resume at the next instruction after warm-up or a vectorless wake.
            o_resume_next <= ((state_r == ST_WARM) & wu_done) |
                             ((state_r == ST_DOZE) & doze_wake & ~master_ie_r);
            o_irq_service <= ((state_r == ST_DOZE) & doze_wake & master_ie_r) |
                             ((state_r == ST_RUN) & doze_req & i_wdt_irq);
        end
    end
endmodule

// ---- design/lpm_consts.vh ----
// Functional notes
// - Level release: leave halt while release pin high or enabled key input low.
// - Level release: halt request with release active goes straight to warm-up.
// - Once warm-up starts, halt is never re-entered during it.
// - Edge-to-level change waits for a release pin rising edge first.
// - Edge release: leave halt only on release pin rising edge.
// - Edge release: halt is entered even while release pin is high.
// - Release restarts oscillators per dual/single clock and resume target.
// - Warm-up period follows release; everything stays halted meanwhile.
// - Warm-up length picked by 3-bit field, six settings, two ignore top bit.
// - Warm-up timed by dividing the basic clock, no separate source.
// - After warm-up, execution resumes at the instruction after the halt request.
// - Prescaler and timing divider cleared on release before restart.
// - Reset low during halt ends it and performs normal reset.
// - Doze stops CPU and watchdog; peripherals keep running.
// - Doze holds memory, registers, status word, port latches, PC plus two.
// - Leaving doze clears doze bit and returns to prior operating mode.
// - Reset ends doze; device starts in single-clock fast mode.
// - Master enable 0: enabled source ends doze, no vector, next instruction.
// - Master enable 1: enabled source ends doze and is serviced.
// - Warm-up lengths in fast or slow clock cycles per setting.
// - Resume bit picks fast or slow return; reset returns single fast mode.
// - Watchdog interrupt just before doze: serviced, doze not entered.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
`define OFS_SYSCTL1 4'h0
`define OFS_SYSCTL2 4'h4
`define OFS_KEYEN 4'h8
`define OFS_IRQCTL 4'hC
`define OFS_IRQEN 5'h10
`define OFS_STATUS 5'h14
`define BIT_STOP 7
`define BIT_RELEASE_METHOD_SELECT 6
`define BIT_RESUME_MODE_SELECT 5
`define BIT_OUTEN 4
`define BIT_XEN 7
`define BIT_XTEN 6
`define BIT_SYSCK 5
`define BIT_DOZE 4
`define RST_SYSCTL1 8'h00
`define RST_SYSCTL2 8'h80
`define FS_DIV_CYC 10'd610
`define WU_W 18
`endif

// ---- design/warmup_timer.v ----
`include "lpm_consts.vh"
module warmup_timer (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rst_n,
    // Control.
    input wire i_start,
    input wire i_slow,
    input wire [`WU_W-1:0] i_len,
    // Status.
    output wire o_busy,
    output reg o_done
);
    reg [9:0] div_r;
    reg [`WU_W-1:0] cnt_r;
    reg busy_r;
    reg slow_r;
    wire tick;

    // The slow clock is derived from the basic clock by the divider.
    assign tick = slow_r ? (div_r == `FS_DIV_CYC - 10'd1) : 1'b1;
    assign o_busy = busy_r;

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            div_r <= 10'h000;
            cnt_r <= {`WU_W{1'b0}};
            busy_r <= 1'b0;
            slow_r <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                // Divider restarts from zero so every warm-up is whole.
                div_r <= 10'h000;
                cnt_r <= i_len;
                slow_r <= i_slow;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                div_r <= tick ? 10'h000 : div_r + 10'd1;
                if (tick) begin
                    if (cnt_r <= {{(`WU_W-1){1'b0}}, 1'b1}) begin
                        busy_r <= 1'b0;
                        o_done <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - {{(`WU_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end
endmodule

// ---- dv/lpm_checker_sva.sv ----
`include "lpm_consts.vh"
module lpm_checker #(
    parameter WU_SCALE_SHIFT = 0
) (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rst_n,
    // Pins.
    input wire i_halt_release_pin,
    input wire [3:0] i_key_wakeup_inputs,
    // Clock and core control.
    input wire o_hf_osc_en,
    input wire o_lf_osc_en,
    input wire o_slow_clk_sel,
    input wire o_cpu_stop,
    input wire o_wdt_stop,
    input wire o_periph_stop,
    input wire o_prescaler_clr,
    input wire o_resume_next
);
    timeunit 1ns;
    timeprecision 1ns;
    // Longest slow warm-up; the margin allows for the shortened count rounding up.
    localparam int WU_MAX = (((3 << 13) >> WU_SCALE_SHIFT) + 2) * `FS_DIV_CYC + 16;
    int warm_cnt;
    logic halted;
    assign halted = o_periph_stop && !o_hf_osc_en && !o_lf_osc_en;
    always @(posedge i_mclk) begin
        if (!i_rst_n || o_resume_next) begin
            warm_cnt <= 0;
        end else if (o_prescaler_clr || warm_cnt != 0) begin
            warm_cnt <= warm_cnt + 1;
        end
    end
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    a_reset_values:
        assert property (disable iff (1'h0) !i_rst_n |=> o_hf_osc_en && !o_lf_osc_en && !o_slow_clk_sel && !o_cpu_stop)
        else $error("reset did not restore the run state");
    a_stall_wake:
        assert property ((halted && !i_halt_release_pin && &i_key_wakeup_inputs) [*6] |=> halted)
        else $error("halt left without a release cause");
    a_warm_bounded:
        assert property (warm_cnt <= WU_MAX)
        else $error("warm-up never finished");
    a_warm_halted:
        assert property (o_prescaler_clr |-> o_cpu_stop && o_periph_stop)
        else $error("core running during warm-up");
    a_clr_pulse:
        assert property (o_prescaler_clr |=> !o_prescaler_clr)
        else $error("divider clear longer than one cycle");
    a_osc_on:
        assert property (o_prescaler_clr |-> o_hf_osc_en || o_lf_osc_en)
        else $error("no oscillator restarted on release");
    a_slow_lf:
        assert property ($rose(o_slow_clk_sel) |-> o_lf_osc_en)
        else $error("slow clock selected with its oscillator off");
    a_doze_wdt:
        assert property (o_cpu_stop && !o_periph_stop |-> o_wdt_stop)
        else $error("watchdog running in doze");
    a_stop_order:
        assert property (o_periph_stop |-> o_cpu_stop && o_wdt_stop)
        else $error("peripherals halted while core runs");
endmodule
bind low_power_mode_controller lpm_checker #(.WU_SCALE_SHIFT(WU_SCALE_SHIFT)) i_lpm_checker (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_halt_release_pin(i_halt_release_pin),
    .i_key_wakeup_inputs(i_key_wakeup_inputs), .o_hf_osc_en(o_hf_osc_en), .o_lf_osc_en(o_lf_osc_en),
    .o_slow_clk_sel(o_slow_clk_sel), .o_cpu_stop(o_cpu_stop), .o_wdt_stop(o_wdt_stop),
    .o_periph_stop(o_periph_stop), .o_prescaler_clr(o_prescaler_clr), .o_resume_next(o_resume_next)
);

// ---- dv/testbench.sv ----
`include "lpm_consts.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] A_S1 = 5'(`OFS_SYSCTL1);
    localparam logic [4:0] A_S2 = 5'(`OFS_SYSCTL2);
    localparam logic [4:0] A_KEY = 5'(`OFS_KEYEN);
    localparam logic [4:0] A_IRC = 5'(`OFS_IRQCTL);
    localparam logic [4:0] A_IRE = 5'(`OFS_IRQEN);
    localparam logic [4:0] A_ST = 5'(`OFS_STATUS);
    typedef struct packed {logic [4:0] a; logic [7:0] d; logic [31:0] r; logic [31:0] e;} row_t;
    row_t rows [6] = '{'{A_S1, 8'h13, 32'h0000_0000, 32'h0000_0012}, '{A_S2, 8'h80, 32'h0000_0080, 32'h0000_0080},
        '{A_KEY, 8'hFF, 32'h0000_0000, 32'h0000_000F}, '{A_IRE, 8'h01, 32'h0000_0000, 32'h0000_0001},
        '{A_ST, 8'hFF, 32'h0000_03C1, 32'h0000_03C1}, '{5'h18, 8'h5A, 32'h0000_0000, 32'h0000_0000}};
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq;
    logic lvl = 1'h0;
    logic pulse = 1'h0;
    logic [3:0] keys_low = 4'h0;
    logic pin;
    logic [3:0] keys;
    logic [7:0] irq = 8'h00;
    logic wdt = 1'h0;
    logic hf, lf, slow, cpu, wdog, per, keep, clr, res, svc;
    logic hf_off_seen = 1'h0;
    logic [31:0] q;
    int err_count = 0;
    int tests_run = 0;
    int c;
    wire [2:0] pulses = {svc, res, clr};
    always #25 mclk = ~mclk;
    always @(negedge mclk) if (hf === 1'h0) hf_off_seen <= 1'h1;
    low_power_mode_controller #(.WU_SCALE_SHIFT(8)) i_low_power_mode_controller (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_halt_release_pin(pin), .i_key_wakeup_inputs(keys), .i_irq_request_latch(irq), .i_wdt_irq(wdt),
        .o_hf_osc_en(hf), .o_lf_osc_en(lf), .o_slow_clk_sel(slow), .o_cpu_stop(cpu), .o_wdt_stop(wdog),
        .o_periph_stop(per), .o_port_out_keep(keep), .o_prescaler_clr(clr), .o_resume_next(res),
        .o_irq_service(svc));
    wake_pin_model i_wake_pin_model (.i_mclk(mclk), .i_level(lvl), .i_pulse(pulse), .i_keys_low(keys_low),
        .o_halt_release_pin(pin), .o_key_wakeup_inputs(keys));
    task automatic close_out();
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The request is held until a rising edge samples waitrequest low; data is taken at that edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h00_0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (waitreq !== 1'h0 && n < 20);
        if (n >= 20) err_count++;
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic wait_pulse(input int sel, input int lim);
        c = 0;
        do begin
            @(negedge mclk);
            c++;
        end while (c < lim && pulses[sel] !== 1'h1);
    endtask
    task automatic edge_pin();
        @(posedge mclk);
        pulse <= 1'h1;
        @(posedge mclk);
        pulse <= 1'h0;
    endtask
    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'h1;
        @(negedge mclk);
        `CHK("rst_hf", 1'h1, hf)
        `CHK("rst_slow", 1'h0, slow)
        `CHK("rst_stop", 1'h0, per | cpu)
    endtask
    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(1'h0, rows[i].a, 8'h00);
            `CHK("reg_rst", rows[i].r, q)
            bus(1'h1, rows[i].a, rows[i].d);
            bus(1'h0, rows[i].a, 8'h00);
            `CHK("reg_rw", rows[i].e, q)
        end
        lvl <= 1'h1;
        repeat (6) @(posedge mclk);
        bus(1'h1, A_S1, 8'h93);
        repeat (8) @(negedge mclk);
        `CHK("edge_halt", 1'h0, hf)
        @(posedge mclk);
        lvl <= 1'h0;
        repeat (8) @(negedge mclk);
        `CHK("no_fall_wake", 1'h1, per)
        edge_pin();
        wait_pulse(0, 12);
        `CHK("edge_wake", 1'h1, c < 12)
        `CHK("warm_hf", 1'h1, hf)
        `CHK("warm_lf", 1'h0, lf)
        wait_pulse(1, 12);
        `CHK("warm_len", 1'h1, c > 1 && c < 9)
        repeat (2) @(negedge mclk);
        `CHK("run_again", 1'h0, cpu)
        bus(1'h1, A_S1, 8'h53);
        bus(1'h0, A_ST, 8'h00);
        `CHK("lvl_wait", 1'h0, q[4])
        edge_pin();
        repeat (10) @(negedge mclk);
        bus(1'h0, A_ST, 8'h00);
        `CHK("lvl_on", 1'h1, q[4])
        bus(1'h1, A_S1, 8'hD3);
        repeat (8) @(negedge mclk);
        `CHK("lvl_halt", 1'h0, hf)
        @(posedge mclk);
        keys_low <= 4'h4;
        wait_pulse(0, 12);
        `CHK("key_wake", 1'h1, c < 12)
        @(posedge mclk);
        keys_low <= 4'h0;
        hf_off_seen <= 1'h0;
        wait_pulse(1, 12);
        `CHK("no_rehalt", 1'h0, hf_off_seen)
        @(posedge mclk);
        keys_low <= 4'h2;
        hf_off_seen <= 1'h0;
        repeat (6) @(posedge mclk);
        bus(1'h1, A_S1, 8'hD3);
        wait_pulse(0, 12);
        `CHK("direct_warm", 1'h1, c < 12)
        wait_pulse(1, 12);
        `CHK("never_halted", 1'h0, hf_off_seen)
        @(posedge mclk);
        keys_low <= 4'h0;
        bus(1'h1, A_S2, 8'hC0);
        bus(1'h1, A_S1, 8'hB3);
        repeat (8) @(negedge mclk);
        edge_pin();
        wait_pulse(0, 12);
        `CHK("slow_hf", 1'h0, hf)
        `CHK("slow_lf", 1'h1, lf)
        wait_pulse(1, 1300);
        `CHK("slow_len", 1'h1, c > 300 && c < 1300)
        repeat (2) @(negedge mclk);
        `CHK("slow_sel", 1'h1, slow)
        bus(1'h1, A_S1, 8'hA3);
        repeat (8) @(negedge mclk);
        `CHK("halt_keep", 1'h0, keep)
        @(posedge mclk);
        do_reset();
        for (int m = 0; m < 2; m++) begin
            bus(1'h1, A_IRC, {7'h00, m[0]});
            bus(1'h1, A_IRE, 8'h01);
            bus(1'h1, A_S2, 8'h90);
            repeat (3) @(negedge mclk);
            `CHK("doze_stop", 2'h3, {cpu, wdog})
            `CHK("doze_per", 1'h0, per)
            `CHK("doze_keep", 1'h1, keep)
            @(posedge mclk);
            irq <= 8'h01;
            wait_pulse(m + 1, 12);
            `CHK("doze_wake", 1'h1, c < 12)
            @(posedge mclk);
            irq <= 8'h00;
            bus(1'h0, A_S2, 8'h00);
            `CHK("doze_clr", 32'h0000_0080, q)
        end
        @(posedge mclk);
        wdt <= 1'h1;
        bus(1'h1, A_S2, 8'h90);
        wait_pulse(2, 12);
        `CHK("wdt_svc", 1'h1, c < 12)
        `CHK("wdt_nodoze", 1'h0, cpu)
        close_out();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        close_out();
    end
endmodule

// ---- dv/wake_pin_model.sv ----
module wake_pin_model (
    // Clock.
    input wire i_mclk,
    // Commands from the bench.
    input wire i_level,
    input wire i_pulse,
    input wire [3:0] i_keys_low,
    // Pins.
    output wire o_halt_release_pin,
    output wire [3:0] o_key_wakeup_inputs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hold_r = 3'h0;
    // A pulse lasts four cycles so that the two-flop synchroniser cannot miss it.
    always @(posedge i_mclk) begin
        if (i_pulse) begin
            hold_r <= 3'h4;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end
    end
    // The release pin idles low and the keys are pulled high unless pressed.
    assign o_halt_release_pin = i_level | (hold_r != 3'h0);
    assign o_key_wakeup_inputs = ~i_keys_low;
endmodule
